// file: psw_pkg.sv
// psw_pkg: field layout, reset values and encodings for the status/pc block
// assumes: single processor clock, used by every psw design file except psw_sync2
package psw_pkg;

  localparam int PSW_WIDTH = 64;
  localparam int PC_WIDTH = 64;

  // current status word fields; PSO is held only in the saved frame word
  localparam int SWF_LSB = 0;
  localparam int SWF_MSB = 1;
  localparam int IIP_BIT = 2;
  localparam int CAM_LSB = 3;
  localparam int CAM_MSB = 4;
  localparam int MON_BIT = 7;
  localparam int PRI_LSB = 8;
  localparam int PRI_MSB = 12;
  localparam int PSO_LSB = 56;
  localparam int PSO_MSB = 61;

  localparam logic [63:0] PSW_RESET = 64'h0000_0000_0000_1F00;
  localparam logic [63:0] PSW_CUR_MASK = 64'h0000_0000_0000_1F9F;
  localparam logic [63:0] PSW_SAVED_MASK = 64'h3F00_0000_0000_1F9F;
  localparam logic [63:0] PC_RESET = 64'h0000_0000_0000_0000;
  localparam logic [4:0] PRI_MAX = 5'h1F;

  // event frame layout, byte offsets from new stack pointer
  localparam logic [63:0] FRAME_SIZE = 64'h0000_0000_0000_0040;
  localparam logic [63:0] FRAME_PC_OFS = 64'h0000_0000_0000_0030;
  localparam logic [63:0] FRAME_PSW_OFS = 64'h0000_0000_0000_0038;
  localparam logic [63:0] ALIGN_MASK = 64'h0000_0000_0000_003F;

  typedef enum logic [1:0] {
    MODE_KERNEL = 2'h0,
    MODE_EXEC = 2'h1,
    MODE_SUPER = 2'h2,
    MODE_USER = 2'h3
  } psw_mode_type;

  typedef enum logic [1:0] {
    EVT_EXCEPTION = 2'h0,
    EVT_INTERRUPT = 2'h1,
    EVT_ASYNC_TRAP = 2'h2,
    EVT_MACHINE_CHECK = 2'h3
  } psw_event_type;

endpackage

// file: psw_sync2.sv
// psw_sync2: two-flop synchroniser for one pin level
// assumes: destination clock is the processor clock
`timescale 1ns/1ps
module psw_sync2 (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // level
  input wire logic din,
  output logic dout
);

  logic meta_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

// file: psw_frame_store.sv
// psw_frame_store: one-word write port toward the target stack
// assumes: memory outside accepts a write every cycle it is offered
`timescale 1ns/1ps
module psw_frame_store import psw_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // request
  input wire logic wrReq,
  input wire logic [63:0] wrAddr,
  input wire logic [63:0] wrData,
  // memory side
  output logic memWrite,
  output logic [63:0] memAddr,
  output logic [63:0] memData
);

  logic writeD;
  logic [63:0] addrD;
  logic [63:0] dataD;

  always_comb begin
    writeD = wrReq;
    addrD = wrReq ? wrAddr : memAddr;
    dataD = wrReq ? wrData : memData;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memWrite <= 1'b0;
      memAddr <= 64'h0;
      memData <= 64'h0;
    end else if (clkEn) begin
      memWrite <= writeD;
      memAddr <= addrD;
      memData <= dataD;
    end
  end

endmodule

// file: psw_status_pc.sv
// psw_status_pc: processor status word and program counter, event entry and return
// assumes: sequencer outside drives event, return and privileged call strobes on this clock;
// stack memory takes one write per cycle; interrupt level requests come from pins.
`timescale 1ns/1ps
module psw_status_pc import psw_pkg::*; (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // event entry
  input wire logic eventStart,
  input wire logic [1:0] eventKind,
  input wire logic [1:0] eventMode,
  input wire logic [4:0] eventPriority,
  input wire logic eventRaisePri,
  input wire logic [63:0] eventPc,
  input wire logic [63:0] stackPtrIn,
  // return from event
  input wire logic returnStart,
  input wire logic [63:0] savedPcIn,
  input wire logic [63:0] savedPswIn,
  input wire logic [63:0] returnFrameBase,
  // privileged calls
  input wire logic readStatusCall,
  input wire logic writeStatusSoftwareCall,
  input wire logic [1:0] softwareFieldIn,
  input wire logic monitorSet,
  input wire logic monitorValue,
  // branch
  input wire logic branchTaken,
  input wire logic jumpAlways,
  input wire logic [63:0] branchTarget,
  input wire logic [63:0] nextPc,
  // interrupt request pins
  input wire logic intRequestPin,
  input wire logic [4:0] intLevelPin,
  // status and pc out
  output logic [63:0] processorStatusWord,
  output logic [63:0] instructionPointer,
  output logic [63:0] readData,
  output logic readValid,
  output logic [63:0] restoredStackPtr,
  output logic restoreValid,
  output logic intTake,
  // stack write port
  output logic memWrite,
  output logic [63:0] memAddr,
  output logic [63:0] memData
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rstMeta_q;
  logic rstSync_q;
  logic rstnLocal;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  assign rstnLocal = rstSync_q;

  logic intReqSync;
  logic [4:0] intLevelSync;

  psw_sync2 uReqSync (
    .clock(clock),
    .rstn(rstnLocal),
    .din(intRequestPin),
    .dout(intReqSync)
  );

  // per-bit sync; level and request pass the same two flops and are used in the same cycle, with no extra cycle for skew
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : gLevel
      psw_sync2 uLvlSync (
        .clock(clock),
        .rstn(rstnLocal),
        .din(intLevelPin[gi]),
        .dout(intLevelSync[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // state machine: idle, push pc, push status

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PUSH_PC,
    ST_PUSH_PSW
  } psw_state_type;

  psw_state_type state_q, state_d;
  logic [63:0] psw_q, psw_d;
  logic [63:0] pc_q, pc_d;
  logic [63:0] framePsw_q, framePsw_d;
  logic [63:0] framePc_q, framePc_d;
  logic [63:0] frameBase_q, frameBase_d;
  logic [63:0] readData_q, readData_d;
  logic readValid_q, readValid_d;
  logic [63:0] restSp_q, restSp_d;
  logic restValid_q, restValid_d;
  logic intTake_q, intTake_d;

  logic storeReq;
  logic [63:0] storeAddr;
  logic [63:0] storeData;
  logic [63:0] alignedSp;
  logic [63:0] savedImage;

  always_comb begin
    state_d = state_q;
    psw_d = psw_q;
    pc_d = pc_q;
    framePsw_d = framePsw_q;
    framePc_d = framePc_q;
    frameBase_d = frameBase_q;
    readData_d = readData_q;
    readValid_d = 1'b0;
    restSp_d = restSp_q;
    restValid_d = 1'b0;
    intTake_d = 1'b0;
    storeReq = 1'b0;
    storeAddr = 64'h0;
    storeData = 64'h0;
    // frame is 64-byte aligned below the current stack pointer
    alignedSp = (stackPtrIn & ~ALIGN_MASK) - FRAME_SIZE;
    savedImage = psw_q & PSW_CUR_MASK;
    savedImage[PSO_MSB:PSO_LSB] = stackPtrIn[5:0];

    // deferred requests simply wait: only a level above current priority fires
    if (intReqSync && (intLevelSync > psw_q[PRI_MSB:PRI_LSB]) && state_q == ST_IDLE) begin
      intTake_d = 1'b1;
    end

    unique case (state_q)
      ST_IDLE: begin
        if (eventStart) begin
          // only status and pc are captured; mapping context is untouched
          framePsw_d = savedImage & PSW_SAVED_MASK;
          framePc_d = {eventPc[63:2], 2'b00};
          frameBase_d = alignedSp;
          psw_d[CAM_MSB:CAM_LSB] = eventMode;
          if (eventKind != EVT_MACHINE_CHECK) begin
            psw_d[SWF_MSB:SWF_LSB] = 2'b00;
          end
          if (eventKind == EVT_INTERRUPT) begin
            psw_d[IIP_BIT] = 1'b1;
          end
          if (eventRaisePri && eventKind != EVT_EXCEPTION) begin
            psw_d[PRI_MSB:PRI_LSB] = eventPriority;
          end
          state_d = ST_PUSH_PC;
        end else if (returnStart) begin
          pc_d = {savedPcIn[63:2], 2'b00};
          psw_d = savedPswIn & PSW_CUR_MASK;
          restSp_d = (returnFrameBase + FRAME_SIZE) | {58'h0, savedPswIn[PSO_MSB:PSO_LSB]};
          restValid_d = 1'b1;
        end else begin
          if (branchTaken) begin
            pc_d = {branchTarget[63:2], 2'b00};
            if (jumpAlways) begin
              readData_d = {nextPc[63:2], 2'b00};
              readValid_d = 1'b1;
            end
          end
          if (readStatusCall) begin
            readData_d = psw_q & PSW_CUR_MASK;
            readValid_d = 1'b1;
          end
          if (writeStatusSoftwareCall) begin
            psw_d[SWF_MSB:SWF_LSB] = softwareFieldIn;
          end
          if (monitorSet) begin
            psw_d[MON_BIT] = monitorValue;
          end
        end
      end
      ST_PUSH_PC: begin
        storeReq = 1'b1;
        storeAddr = frameBase_q + FRAME_PC_OFS;
        storeData = framePc_q;
        state_d = ST_PUSH_PSW;
      end
      ST_PUSH_PSW: begin
        storeReq = 1'b1;
        storeAddr = frameBase_q + FRAME_PSW_OFS;
        storeData = framePsw_q;
        state_d = ST_IDLE;
      end
      // unused fourth code falls back to idle rather than sticking
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    psw_d = psw_d & PSW_CUR_MASK;
  end

  always_ff @(posedge clock or negedge rstnLocal) begin
    if (!rstnLocal) begin
      state_q <= ST_IDLE;
      psw_q <= PSW_RESET;
      pc_q <= PC_RESET;
      framePsw_q <= 64'h0;
      framePc_q <= 64'h0;
      frameBase_q <= 64'h0;
      readData_q <= 64'h0;
      readValid_q <= 1'b0;
      restSp_q <= 64'h0;
      restValid_q <= 1'b0;
      intTake_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      psw_q <= psw_d;
      pc_q <= pc_d;
      framePsw_q <= framePsw_d;
      framePc_q <= framePc_d;
      frameBase_q <= frameBase_d;
      readData_q <= readData_d;
      readValid_q <= readValid_d;
      restSp_q <= restSp_d;
      restValid_q <= restValid_d;
      intTake_q <= intTake_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack write port

  psw_frame_store uStore (
    .clock(clock),
    .rstn(rstnLocal),
    .clkEn(clkEn),
    .wrReq(storeReq),
    .wrAddr(storeAddr),
    .wrData(storeData),
    .memWrite(memWrite),
    .memAddr(memAddr),
    .memData(memData)
  );

  assign processorStatusWord = psw_q;
  assign instructionPointer = pc_q;
  assign readData = readData_q;
  assign readValid = readValid_q;
  assign restoredStackPtr = restSp_q;
  assign restoreValid = restValid_q;
  assign intTake = intTake_q;

endmodule

// file: psw_chk_assertions.sv
// psw_chk: port checker for psw_status_pc
// assumes: events spaced and clkEn high around them
`timescale 1ns/1ps
module psw_chk import psw_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // requests
  input wire logic eventStart,
  input wire logic [1:0] eventKind,
  input wire logic [1:0] eventMode,
  input wire logic [63:0] eventPc,
  input wire logic [63:0] stackPtrIn,
  input wire logic returnStart,
  input wire logic [63:0] savedPcIn,
  input wire logic [63:0] savedPswIn,
  input wire logic [63:0] returnFrameBase,
  input wire logic writeStatusSoftwareCall,
  input wire logic [1:0] softwareFieldIn,
  input wire logic monitorSet,
  input wire logic jumpAlways,
  // answers
  input wire logic [63:0] processorStatusWord,
  input wire logic [63:0] instructionPointer,
  input wire logic [63:0] readData,
  input wire logic readValid,
  input wire logic [63:0] restoredStackPtr,
  input wire logic restoreValid,
  input wire logic memWrite,
  input wire logic [63:0] memAddr,
  input wire logic [63:0] memData
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // push cycles refuse strobes, so only idle requests count
  sequence evtGo;
    eventStart && clkEn && !$past(eventStart) && !memWrite;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_RESERVED: assert property ((processorStatusWord & ~PSW_CUR_MASK) == 64'h0)
    else $error("reserved status bits set");
  AST_BOOT: assert property ($rose(rstn) |-> processorStatusWord == PSW_RESET)
    else $error("bootstrap status wrong");
  AST_READ: assert property (readValid && !$past(jumpAlways) |-> readData == $past(processorStatusWord))
    else $error("read data differs from status");
  AST_WRITE: assert property (writeStatusSoftwareCall && clkEn && !eventStart && !returnStart && !monitorSet
    && !$past(eventStart) && !memWrite
    |=> processorStatusWord == {$past(processorStatusWord[63:2]), $past(softwareFieldIn)})
    else $error("software write disturbed status");
  AST_PUSH_PC: assert property (evtGo |-> ##2 memWrite && memData == {$past(eventPc[63:2], 2), 2'h0}
    && memAddr == ($past(stackPtrIn, 2) & ~ALIGN_MASK) - FRAME_SIZE + FRAME_PC_OFS)
    else $error("pc slot of frame wrong");
  AST_PUSH_PSW: assert property (evtGo |-> ##3 memWrite
    && memAddr == ($past(stackPtrIn, 3) & ~ALIGN_MASK) - FRAME_SIZE + FRAME_PSW_OFS
    && memData == {2'h0, $past(stackPtrIn[5:0], 3), $past(processorStatusWord[55:0], 3)})
    else $error("status slot of frame wrong");
  AST_ENTRY: assert property (evtGo |=> processorStatusWord[4:3] == $past(eventMode)
    && (processorStatusWord[1:0] == 2'h0 || $past(eventKind) == EVT_MACHINE_CHECK))
    else $error("entry mode or software field wrong");
  AST_INT_FLAG: assert property (evtGo ##0 eventKind == EVT_INTERRUPT |=> processorStatusWord[IIP_BIT])
    else $error("interrupt flag not set");
  AST_RETURN: assert property (returnStart && clkEn && !eventStart && !$past(eventStart) && !memWrite
    |=> restoreValid && instructionPointer[63:2] == $past(savedPcIn[63:2])
    && processorStatusWord == ($past(savedPswIn) & PSW_CUR_MASK)
    && restoredStackPtr == (($past(returnFrameBase) + FRAME_SIZE) | {58'h0, $past(savedPswIn[61:56])}))
    else $error("return restore wrong");
  CV_EVENT: cover property (evtGo ##3 memWrite);
  CV_RETURN: cover property (restoreValid);
  CV_READ: cover property (readValid);
endmodule
bind psw_status_pc psw_chk chk_u (.clock, .rstn, .clkEn, .eventStart, .eventKind, .eventMode, .eventPc,
  .stackPtrIn, .returnStart, .savedPcIn, .savedPswIn, .returnFrameBase, .writeStatusSoftwareCall,
  .softwareFieldIn, .monitorSet, .jumpAlways, .processorStatusWord, .instructionPointer, .readData,
  .readValid, .restoredStackPtr, .restoreValid, .memWrite, .memAddr, .memData);

// file: tb_top.sv
// tb_top: directed bench for psw_status_pc
// assumes: package, design and checker compiled first
`timescale 1ns/1ps
module tb_top import psw_pkg::*; ;
  logic clock = 1'h0, rstn = 1'h0, clkEn = 1'h1, eventStart = 1'h0, eventRaisePri = 1'h1, returnStart = 1'h0;
  logic readStatusCall = 1'h0, writeStatusSoftwareCall = 1'h0, monitorSet = 1'h0, monitorValue = 1'h0;
  logic branchTaken = 1'h0, jumpAlways = 1'h0, intRequestPin = 1'h0;
  logic [1:0] eventKind = 2'h0, eventMode = 2'h0, softwareFieldIn = 2'h0;
  logic [4:0] eventPriority = 5'h10, intLevelPin = 5'h0;
  logic [63:0] eventPc = 64'h0, stackPtrIn = 64'h0, savedPcIn = 64'h0, savedPswIn = 64'h0;
  logic [63:0] returnFrameBase = 64'h0, branchTarget = 64'h0, nextPc = 64'h0;
  logic [63:0] processorStatusWord, instructionPointer, readData, restoredStackPtr, memAddr, memData;
  logic readValid, restoreValid, intTake, memWrite;
  int num_errors = 0, checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////
  psw_status_pc dut_u (.clock, .rstn, .clkEn, .eventStart, .eventKind, .eventMode, .eventPriority,
    .eventRaisePri, .eventPc, .stackPtrIn, .returnStart, .savedPcIn, .savedPswIn, .returnFrameBase,
    .readStatusCall, .writeStatusSoftwareCall, .softwareFieldIn, .monitorSet, .monitorValue, .branchTaken,
    .jumpAlways, .branchTarget, .nextPc, .intRequestPin, .intLevelPin, .processorStatusWord,
    .instructionPointer, .readData, .readValid, .restoredStackPtr, .restoreValid, .intTake, .memWrite,
    .memAddr, .memData);
  ////////////////////////////////////////////////////////////
  task wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] e, input logic [63:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // settle past the edge before looking
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task test_calls();
    @(posedge clock);
    readStatusCall <= 1'h1;
    softwareFieldIn <= 2'h2;
    @(posedge clock);
    readStatusCall <= 1'h0;
    writeStatusSoftwareCall <= 1'h1;
    @(posedge clock);
    writeStatusSoftwareCall <= 1'h0;
    monitorValue <= 1'h1;
    monitorSet <= 1'h1;
    @(posedge clock);
    monitorSet <= 1'h0;
    tick(1);
    chk("psw", 64'h1F82, processorStatusWord);
    @(posedge clock);
    branchTarget <= 64'h4000;
    nextPc <= 64'h5004;
    branchTaken <= 1'h1;
    jumpAlways <= 1'h1;
    readStatusCall <= 1'h1;
    monitorValue <= 1'h0;
    monitorSet <= 1'h1;
    @(posedge clock);
    branchTaken <= 1'h0;
    jumpAlways <= 1'h0;
    readStatusCall <= 1'h0;
    monitorSet <= 1'h0;
    #1;
    chk("readData", 64'h1F82, readValid ? readData : '1);
    chk("pc", 64'h4000, instructionPointer);
    chk("psw", 64'h1F02, processorStatusWord);
    @(posedge clock);
    branchTaken <= 1'h1;
    jumpAlways <= 1'h1;
    @(posedge clock);
    branchTaken <= 1'h0;
    jumpAlways <= 1'h0;
    #1;
    chk("jumpData", 64'h5004, readValid ? readData : '1);
    $display("calls done");
  endtask
  // a write offered while the enable is low must not land
  task test_freeze();
    @(posedge clock);
    clkEn <= 1'h0;
    softwareFieldIn <= 2'h1;
    writeStatusSoftwareCall <= 1'h1;
    @(posedge clock);
    @(posedge clock);
    writeStatusSoftwareCall <= 1'h0;
    clkEn <= 1'h1;
    #1;
    chk("frozenPsw", 64'h1F02, processorStatusWord);
    $display("freeze done");
  endtask
  task test_event(input logic [1:0] k);
    logic [4:0] pri;
    logic [1:0] sw;
    pri = (k == EVT_INTERRUPT || k == EVT_MACHINE_CHECK) ? 5'h10 : 5'h04;
    sw = (k == EVT_MACHINE_CHECK) ? 2'h3 : 2'h0;
    @(posedge clock);
    savedPswIn <= 64'hD500_0000_0000_047B;
    savedPcIn <= 64'h2000_0004;
    returnFrameBase <= 64'h1000;
    returnStart <= 1'h1;
    @(posedge clock);
    returnStart <= 1'h0;
    #1;
    chk("retPc", 64'h2000_0004, restoreValid ? instructionPointer : '1);
    chk("retPsw", 64'h041B, processorStatusWord);
    chk("retSp", 64'h1055, restoredStackPtr);
    @(posedge clock);
    eventKind <= k;
    eventMode <= k;
    stackPtrIn <= 64'h8027;
    eventPc <= 64'h300B;
    eventRaisePri <= (k != EVT_ASYNC_TRAP);
    eventStart <= 1'h1;
    @(posedge clock);
    eventStart <= 1'h0;
    #1;
    chk("entryPsw", {51'h0, pri, 3'h0, k, k == EVT_INTERRUPT, sw}, processorStatusWord);
    tick(1);
    chk("pcAddr", 64'h7FF0, memWrite ? memAddr : '1);
    chk("pcData", 64'h3008, memData);
    tick(1);
    chk("pswAddr", 64'h7FF8, memWrite ? memAddr : '1);
    chk("pswData", 64'h2700_0000_0000_041B, memData);
    $display("event %0d done", k);
  endtask
  task test_int();
    @(posedge clock);
    intLevelPin <= 5'h10;
    intRequestPin <= 1'h1;
    tick(6);
    chk("intTakeEqual", 64'h0, {63'h0, intTake});
    @(posedge clock);
    intLevelPin <= 5'h11;
    tick(5);
    chk("intTakeAbove", 64'h1, {63'h0, intTake});
    @(posedge clock);
    intRequestPin <= 1'h0;
    $display("interrupt done");
  endtask
  ////////////////////////////////////////////////////////////
  initial forever #5 clock = ~clock;
  // a hang is cut short well past the ~60 cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    tick(5);
    chk("bootPsw", PSW_RESET, processorStatusWord);
    test_calls();
    test_freeze();
    for (int k = 0; k < 4; k++) test_event(2'(k));
    test_int();
    wrap_up();
  end
endmodule
